// [rtl/mcrb_pkg.sv]
// Purpose: shared constants and types of the motor configuration bank
// Assumes: system clock of 40 MHz
// Notes: status bits 7:5 and address 9 bits 13:0 are not stored here
package mcrb_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NONVOLATILE_LOAD_OP_TIME_NS = 1000;
  localparam int NONVOLATILE_SAVE_OP_TIME_NS = 10000;
  // least times, rounded up to whole cycles
  localparam int NONVOLATILE_LOAD_OP_CYC =
    (NONVOLATILE_LOAD_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NONVOLATILE_SAVE_OP_CYC =
    (NONVOLATILE_SAVE_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_TMR_W = 9;

  localparam int NUM_WORDS = 10;
  localparam logic [7:0] LAST_ADDR = 8'h09;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] ADDR9_MASK = 16'hc000;
  localparam logic [7:0] STATUS_WRITE_OP_MASK = 8'h0e;
  localparam logic [3:0] CNT_BYTE_LAST = 4'h7;
  localparam logic [3:0] CNT_WORD_LAST = 4'hf;

  localparam int SR_BUSY_BIT = 0;
  localparam int SR_GATE_BIT = 1;
  localparam int SR_WIRE_BIT = 2;
  localparam int SR_NONVOLATILE_WRITE_GATE_BIT = 3;
  localparam int SR_CAL_BIT = 4;

  localparam int LOOP_MODE_BIT = 0;
  localparam int TACH_SRC_BIT = 15;
  localparam int LOOP_MODE_ADDR = 5;
  localparam int TACH_SRC_ADDR = 8;

  localparam logic [7:0] CODE_SR_RD = 8'h49;
  localparam logic [7:0] CODE_SR_WR = 8'h4a;
  localparam logic [7:0] CODE_REG_RD = 8'h51;
  localparam logic [7:0] CODE_REG_WR = 8'h52;
  localparam logic [7:0] CODE_NONVOLATILE_LOAD_OP = 8'h59;
  localparam logic [7:0] CODE_NONVOLATILE_SAVE_OP = 8'h5a;
  localparam logic [7:0] CODE_NONVOLATILE_ABORT_OP = 8'h5c;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CODE = 3'b001,
    ST_ADDR = 3'b011,
    ST_DIN = 3'b010,
    ST_DOUT = 3'b110,
    ST_SKIP = 3'b111
  } mcrb_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SR_RD = 3'h1,
    OP_SR_WR = 3'h2,
    OP_REG_RD = 3'h3,
    OP_REG_WR = 3'h4
  } mcrb_op_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'h0,
    NV_LOAD = 2'h1,
    NV_SAVE = 2'h2
  } mcrb_nv_t;
endpackage : mcrb_pkg

// [rtl/mcrb_sync3.sv]
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: input is asynchronous to i_clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module mcrb_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      level_ff <= RST_VAL;
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign o_level = level_ff;
  assign o_rise = (s2_ff == s3_ff) && s3_ff && !level_ff;
  assign o_fall = (s2_ff == s3_ff) && !s3_ff && level_ff;
endmodule : mcrb_sync3

// [rtl/mcrb_top.sv]
// Purpose: configuration register bank reached over the serial link
// Assumes: link select, clock and data pins asynchronous to I_CLK_SYS
// Notes: host samples and device shifts on rising link clock edges
// Overview of operation
// R1: busy bit high during normal reads, writes and nonvolatile operations.
// R2: gate bit low admits only status read and write commands.
// R3: wire bit chooses three-wire or two-wire data pins for the link.
// R4: nonvolatile mode bit allows loading at 0, saving at 1.
// R5: status bit 4 reports hall detection failure as 1.
// R6: address 1 holds nonstop enable, halt threshold and launch duty.
// R7: address 2 holds slope break duty and top duty.
// R8: address 3 holds launch speed and loop return hysteresis.
// R9: address 4 holds first slope and two open-loop switches.
// R10: address 5 holds second slope, reverse warning and loop mode.
// R11: address 6 holds two seven-bit gains each with times eight scaling.
// R12: address 7 holds standby, sense, magnet, speed and hall fields.
// R13: address 8 bit 15 selects tach source, 14:12 pulse format.
// R14: address 8 bits 11:9 select command type, invert, reverse launch.
// R15: address 8 bit 8 selects commutation, bit 7 latches short trip.
// R16: address 8 holds blank time, current limit and switching rate.
// R17: address 9 holds stall check on and off time selections.
// R18: status read and normal read codes decoded with their data lengths.
// R19: status write, normal write, load, save and abort codes decoded.
// R20: command code enters serial mode; frame end leaves it if gate low.
// R21: host sends commands only while the tach pin floats.
// R22: status bits 7:5 read zero; all register fields reset to zero.
// R23: busy and calibration flags read-only; other three status bits writable.
`timescale 1ns/1ps
module mcrb_top (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_LINK_SEL_B,
  input wire logic I_SPEED_CMD_PIN,
  input wire logic I_TACH_PIN,
  input wire logic I_HALL_CAL_FAIL,
  output logic O_TACH_OUT,
  output logic O_TACH_OE_B,
  output logic O_ALERT_OUT,
  output logic O_ALERT_OE_B,
  output logic O_SERIAL_MODE,
  output logic [7:0] O_STATUS,
  output logic [16*mcrb_pkg::NUM_WORDS-1:0] O_CFG_WORDS,
  output logic O_LOOP_OPEN,
  output logic O_TACH_SRC
);
  import mcrb_pkg::*;

  logic rst_s1_ff;
  logic rst_n;
  logic sel_lvl, sel_rise, sel_fall;
  logic sck_rise;
  logic din_lvl;
  mcrb_state_t state_ff;
  mcrb_op_t op_ff;
  logic [3:0] cnt_ff;
  logic [15:0] shin_ff;
  logic [15:0] shout_ff;
  logic [7:0] addr_ff;
  logic [15:0] wdata_ff;
  logic sr_wr_pls_ff, reg_wr_pls_ff;
  logic load_go_ff, save_go_ff, abort_go_ff;
  logic gate_ff, wire_ff, nonvolatile_write_gate_ff, busy_ff, cal_err_ff;
  logic serial_mode_ff;
  logic [15:0] cfg_ff [NUM_WORDS];
  logic [15:0] nvm_mem [NUM_WORDS];
  mcrb_nv_t nv_ff;
  logic [NVM_TMR_W-1:0] tmr_ff;
  logic tach_oe_b_ff, alert_oe_b_ff, tach_out_ff, alert_out_ff;
  logic [7:0] status_ff;
  logic shift_evt, decode_evt, nv_done;
  logic [7:0] code_w;
  logic [15:0] word_w;
  logic refuse_w;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  mcrb_sync3 #(.RST_VAL(1'b1)) u_sel (
    .i_clk(I_CLK_SYS), .i_rst_n(rst_n), .i_async(I_LINK_SEL_B),
    .o_level(sel_lvl), .o_rise(sel_rise), .o_fall(sel_fall));
  mcrb_sync3 #(.RST_VAL(1'b0)) u_sck (
    .i_clk(I_CLK_SYS), .i_rst_n(rst_n), .i_async(I_SPEED_CMD_PIN),
    .o_level(), .o_rise(sck_rise), .o_fall());
  // data always enters on the tach pin in both wire modes
  mcrb_sync3 #(.RST_VAL(1'b0)) u_din (
    .i_clk(I_CLK_SYS), .i_rst_n(rst_n), .i_async(I_TACH_PIN),
    .o_level(din_lvl), .o_rise(), .o_fall());

  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [15:0] v;
    v = WORD_RESET;
    for (int i = 0; i < NUM_WORDS; i++) begin
      if (a == 8'(i)) begin
        v = cfg_ff[i];
      end
    end
    return v;
  endfunction : rd_word

  assign shift_evt = sck_rise && !sel_lvl && !sel_rise && !sel_fall;
  assign decode_evt = shift_evt && (state_ff == ST_CODE)
    && (cnt_ff == CNT_BYTE_LAST);
  assign code_w = {shin_ff[6:0], din_lvl};
  assign word_w = {shin_ff[14:0], din_lvl};
  // reg, load and save ops are refused during nonvolatile work; gate low admits status ops only
  assign refuse_w = (!gate_ff && (code_w != CODE_SR_RD)
    && (code_w != CODE_SR_WR)) // R2
    || ((nv_ff != NV_IDLE) && (code_w != CODE_SR_RD)
    && (code_w != CODE_SR_WR) && (code_w != CODE_NONVOLATILE_ABORT_OP));

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_NONE;
      cnt_ff <= 4'h0;
      shin_ff <= 16'h0000;
      shout_ff <= 16'h0000;
      addr_ff <= 8'h00;
      wdata_ff <= 16'h0000;
      sr_wr_pls_ff <= 1'b0;
      reg_wr_pls_ff <= 1'b0;
      load_go_ff <= 1'b0;
      save_go_ff <= 1'b0;
      abort_go_ff <= 1'b0;
    end else begin
      sr_wr_pls_ff <= 1'b0;
      reg_wr_pls_ff <= 1'b0;
      load_go_ff <= 1'b0;
      save_go_ff <= 1'b0;
      abort_go_ff <= 1'b0;
      if (sel_rise) begin
        state_ff <= ST_IDLE;
        op_ff <= OP_NONE;
      end else if (sel_fall) begin
        state_ff <= ST_CODE;
        cnt_ff <= 4'h0;
      end else if (shift_evt) begin
        shin_ff <= word_w;
        cnt_ff <= cnt_ff + 4'h1;
        case (state_ff)
          ST_CODE: begin
            if (cnt_ff == CNT_BYTE_LAST) begin
              cnt_ff <= 4'h0;
              state_ff <= ST_SKIP;
              if (!refuse_w) begin
                case (code_w)
                  CODE_SR_RD: begin // R18
                    op_ff <= OP_SR_RD;
                    shout_ff <= {status_ff, 8'h00};
                    state_ff <= ST_DOUT;
                  end
                  CODE_SR_WR: begin // R19
                    op_ff <= OP_SR_WR;
                    state_ff <= ST_DIN;
                  end
                  CODE_REG_RD: begin // R18
                    op_ff <= OP_REG_RD;
                    state_ff <= ST_ADDR;
                  end
                  CODE_REG_WR: begin // R19
                    op_ff <= OP_REG_WR;
                    state_ff <= ST_ADDR;
                  end
                  CODE_NONVOLATILE_LOAD_OP: load_go_ff <= !nonvolatile_write_gate_ff; // R4
                  CODE_NONVOLATILE_SAVE_OP: save_go_ff <= nonvolatile_write_gate_ff; // R4
                  CODE_NONVOLATILE_ABORT_OP: abort_go_ff <= 1'b1; // R19
                  default: op_ff <= OP_NONE;
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (cnt_ff == CNT_BYTE_LAST) begin
              cnt_ff <= 4'h0;
              addr_ff <= code_w;
              if (op_ff == OP_REG_RD) begin
                shout_ff <= rd_word(code_w);
                state_ff <= ST_DOUT;
              end else begin
                state_ff <= ST_DIN;
              end
            end
          end
          ST_DIN: begin
            if ((op_ff == OP_SR_WR) && (cnt_ff == CNT_BYTE_LAST)) begin
              wdata_ff <= {8'h00, code_w};
              sr_wr_pls_ff <= 1'b1;
              state_ff <= ST_SKIP;
            end else if (cnt_ff == CNT_WORD_LAST) begin
              wdata_ff <= word_w;
              reg_wr_pls_ff <= 1'b1;
              state_ff <= ST_SKIP;
            end
          end
          ST_DOUT: begin
            shout_ff <= {shout_ff[14:0], 1'b0};
            if ((op_ff == OP_SR_RD) ? (cnt_ff == CNT_BYTE_LAST)
                : (cnt_ff == CNT_WORD_LAST)) begin
              state_ff <= ST_SKIP;
            end
          end
          default: cnt_ff <= 4'h0;
        endcase
      end
    end
  end

  // nonvolatile engine; abort only cuts a save short
  assign nv_done = (nv_ff != NV_IDLE) && (tmr_ff == '0);
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      nv_ff <= NV_IDLE;
      tmr_ff <= '0;
    end else if (abort_go_ff && (nv_ff == NV_SAVE)) begin
      nv_ff <= NV_IDLE;
    end else if (load_go_ff) begin
      nv_ff <= NV_LOAD;
      tmr_ff <= NVM_TMR_W'(NONVOLATILE_LOAD_OP_CYC - 1);
    end else if (save_go_ff) begin
      nv_ff <= NV_SAVE;
      tmr_ff <= NVM_TMR_W'(NONVOLATILE_SAVE_OP_CYC - 1);
    end else if (nv_done) begin
      nv_ff <= NV_IDLE;
    end else if (nv_ff != NV_IDLE) begin
      tmr_ff <= tmr_ff - 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        nvm_mem[i] <= WORD_RESET;
      end
    end else if (nv_done && (nv_ff == NV_SAVE)) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        nvm_mem[i] <= cfg_ff[i];
      end
    end
  end

  // fields of words 0..8 are stored whole; word 9 keeps only its top bits
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        cfg_ff[i] <= WORD_RESET; // R22
      end
    end else if (nv_done && (nv_ff == NV_LOAD)) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        cfg_ff[i] <= nvm_mem[i];
      end
      cfg_ff[NUM_WORDS-1] <= nvm_mem[NUM_WORDS-1] & ADDR9_MASK; // R17
    end else if (reg_wr_pls_ff && (addr_ff <= LAST_ADDR)) begin
      // R6 R7 R8 R9 R10 R11 R12 R13 R14 R15 R16
      cfg_ff[addr_ff[3:0]] <= (addr_ff == LAST_ADDR)
        ? (wdata_ff & ADDR9_MASK) : wdata_ff; // R17
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      gate_ff <= 1'b0;
      wire_ff <= 1'b0;
      nonvolatile_write_gate_ff <= 1'b0;
    end else if (sr_wr_pls_ff) begin
      gate_ff <= wdata_ff[SR_GATE_BIT] & STATUS_WRITE_OP_MASK[SR_GATE_BIT]; // R23
      wire_ff <= wdata_ff[SR_WIRE_BIT] & STATUS_WRITE_OP_MASK[SR_WIRE_BIT]; // R3
      nonvolatile_write_gate_ff <= wdata_ff[SR_NONVOLATILE_WRITE_GATE_BIT]; // R4
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cal_err_ff <= 1'b0;
      status_ff <= 8'h00;
    end else begin
      busy_ff <= (nv_ff != NV_IDLE) || (((op_ff == OP_REG_RD)
        || (op_ff == OP_REG_WR)) && (state_ff != ST_IDLE)
        && (state_ff != ST_SKIP)); // R1
      cal_err_ff <= I_HALL_CAL_FAIL; // R5
      status_ff <= {3'b000, cal_err_ff, nonvolatile_write_gate_ff, wire_ff, gate_ff,
        busy_ff}; // R22
    end
  end

  // motor logic stops while serial mode stands
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode_ff <= 1'b0;
    end else if (decode_evt) begin
      serial_mode_ff <= 1'b1; // R20
    end else if (sel_rise && !gate_ff) begin
      serial_mode_ff <= 1'b0; // R20
    end
  end

  // tach pin floats in serial mode except while it carries read data
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      tach_oe_b_ff <= 1'b1;
      alert_oe_b_ff <= 1'b1;
      tach_out_ff <= 1'b0;
      alert_out_ff <= 1'b0;
    end else begin
      tach_oe_b_ff <= !((state_ff == ST_DOUT) && wire_ff); // R3 R21
      alert_oe_b_ff <= !((state_ff == ST_DOUT) && !wire_ff); // R3
      tach_out_ff <= shout_ff[15];
      alert_out_ff <= shout_ff[15];
    end
  end

  assign O_TACH_OUT = tach_out_ff;
  assign O_TACH_OE_B = tach_oe_b_ff;
  assign O_ALERT_OUT = alert_out_ff;
  assign O_ALERT_OE_B = alert_oe_b_ff;
  assign O_SERIAL_MODE = serial_mode_ff;
  assign O_STATUS = status_ff;
  for (genvar g = 0; g < NUM_WORDS; g++) begin : g_cfg
    assign O_CFG_WORDS[16*g +: 16] = cfg_ff[g];
  end
  assign O_LOOP_OPEN = cfg_ff[LOOP_MODE_ADDR][LOOP_MODE_BIT]; // R10
  assign O_TACH_SRC = cfg_ff[TACH_SRC_ADDR][TACH_SRC_BIT]; // R13

  AST_BUSY_IDLE: assert property (@(posedge I_CLK_SYS) // R1
    disable iff (!rst_n) (nv_ff == NV_IDLE) && (state_ff == ST_IDLE)
    |=> !busy_ff) else $error("busy set while idle");
  AST_BUSY_NVM: assert property (@(posedge I_CLK_SYS) // R1
    disable iff (!rst_n) load_go_ff |=> ##1 busy_ff[*2])
    else $error("busy missing during load");
  AST_GATE: assert property (@(posedge I_CLK_SYS) // R2
    disable iff (!rst_n) decode_evt && !gate_ff && (code_w == CODE_REG_WR)
    |=> (state_ff == ST_SKIP) && !load_go_ff)
    else $error("gated command accepted");
  AST_WIRE: assert property (@(posedge I_CLK_SYS) // R3
    disable iff (!rst_n) (state_ff == ST_DOUT) && $stable(state_ff) |=>
    (tach_oe_b_ff == !$past(wire_ff)) && (alert_oe_b_ff == $past(wire_ff)))
    else $error("data pin choice wrong");
  AST_NVM_MODE: assert property (@(posedge I_CLK_SYS) // R4
    disable iff (!rst_n) (load_go_ff |-> !nonvolatile_write_gate_ff)
    and (save_go_ff |-> nonvolatile_write_gate_ff)) else $error("nonvolatile mode ignored");
  AST_CAL: assert property (@(posedge I_CLK_SYS) // R5
    disable iff (!rst_n) I_HALL_CAL_FAIL |=> ##1 O_STATUS[SR_CAL_BIT])
    else $error("calibration failure not shown");
  AST_ADDR9: assert property (@(posedge I_CLK_SYS) // R17
    disable iff (!rst_n) (cfg_ff[NUM_WORDS-1] & ~ADDR9_MASK) == 16'h0000)
    else $error("unused word 9 bits set");
  AST_SR_RSVD: assert property (@(posedge I_CLK_SYS) // R22
    disable iff (!rst_n) O_STATUS[7:5] == 3'b000)
    else $error("reserved status bits set");
  AST_STATUS_WRITE_OP: assert property (@(posedge I_CLK_SYS) // R23
    disable iff (!rst_n) sr_wr_pls_ff
    |=> (gate_ff == $past(wdata_ff[SR_GATE_BIT]))
    && (nonvolatile_write_gate_ff == $past(wdata_ff[SR_NONVOLATILE_WRITE_GATE_BIT])))
    else $error("status write lost");
  AST_SERIAL: assert property (@(posedge I_CLK_SYS) // R20
    disable iff (!rst_n) decode_evt |=> serial_mode_ff)
    else $error("serial mode not entered");
endmodule : mcrb_top

// [verif/mcrb_host_model.sv]
// Purpose: host on the far side of the serial configuration link
// Assumes: 200 ns link clock, held low at select edges
// Notes: undriven wires read as a toggling pattern so a silent device fails
`timescale 1ns/1ps
module mcrb_host_model (
  input wire logic i_clk,
  input wire logic i_tach_out,
  input wire logic i_tach_oe_b,
  input wire logic i_alert_out,
  input wire logic i_alert_oe_b,
  output logic o_sel_b,
  output logic o_sck,
  output logic o_tach_pin
);
  import mcrb_pkg::*;
  localparam time HALF = 100;
  logic d_q;
  logic tgl;
  logic wire2;
  int n_viol;
  initial begin
    o_sel_b = 1'b1;
    o_sck = 1'b0;
    d_q = 1'b0;
    tgl = 1'b0;
    wire2 = 1'b0;
    n_viol = 0;
  end
  always @(posedge i_clk) begin
    tgl <= ~tgl;
  end
  // released line holds the host data bit d_q
  assign o_tach_pin = (i_tach_oe_b == 1'b0) ? i_tach_out : d_q;
  task automatic start;
    @(posedge i_clk);
    #1;
    if (i_tach_oe_b !== 1'b1) n_viol++;
    o_sel_b = 1'b0;
    #HALF;
  endtask : start
  task automatic stop;
    #HALF;
    o_sel_b = 1'b1;
    d_q = ~d_q;
    #(2*HALF);
  endtask : stop
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      d_q = v[i];
      #HALF;
      o_sck = 1'b1;
      #HALF;
      o_sck = 1'b0;
    end
  endtask : send_byte
  task automatic get_byte(output logic [7:0] v);
    d_q = ~d_q;
    for (int i = 7; i >= 0; i--) begin
      #HALF;
      v[i] = wire2 ? (i_tach_oe_b ? tgl : i_tach_out) :
        (i_alert_oe_b ? tgl : i_alert_out);
      o_sck = 1'b1;
      #HALF;
      o_sck = 1'b0;
    end
  endtask : get_byte
  task automatic cmd(input logic [7:0] code);
    start();
    send_byte(code);
    stop();
  endtask : cmd
  task automatic sr_wr(input logic [7:0] v);
    start();
    send_byte(CODE_SR_WR);
    send_byte(v);
    stop();
  endtask : sr_wr
  task automatic sr_rd(output logic [7:0] v);
    start();
    send_byte(CODE_SR_RD);
    get_byte(v);
    stop();
  endtask : sr_rd
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    start();
    send_byte(CODE_REG_WR);
    send_byte(a);
    send_byte(v[15:8]);
    send_byte(v[7:0]);
    stop();
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
    start();
    send_byte(CODE_REG_RD);
    send_byte(a);
    get_byte(v[15:8]);
    get_byte(v[7:0]);
    stop();
  endtask : reg_rd
endmodule : mcrb_host_model

// [verif/test_motor_config_register_bank.sv]
// Purpose: self-checking bench of the configuration register bank
// Assumes: 40 MHz system clock, host model on the link pins
// Notes: random words from a fixed lfsr seed, shadow copy gives expectations
`timescale 1ns/1ps
module test_motor_config_register_bank;
  import mcrb_pkg::*;
  logic clk;
  logic rst_b;
  logic cal_fail;
  logic sel_b, sck, tach_pin, tach_out, tach_oe_b, alert_out, alert_oe_b;
  logic serial_mode, loop_open, tach_src;
  logic [7:0] status;
  logic [7:0] b;
  logic [15:0] got;
  logic [16*NUM_WORDS-1:0] words;
  logic [15:0] shadow [NUM_WORDS];
  logic [31:0] rnd;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  mcrb_top uut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_LINK_SEL_B(sel_b),
    .I_SPEED_CMD_PIN(sck), .I_TACH_PIN(tach_pin),
    .I_HALL_CAL_FAIL(cal_fail), .O_TACH_OUT(tach_out),
    .O_TACH_OE_B(tach_oe_b), .O_ALERT_OUT(alert_out),
    .O_ALERT_OE_B(alert_oe_b), .O_SERIAL_MODE(serial_mode),
    .O_STATUS(status), .O_CFG_WORDS(words), .O_LOOP_OPEN(loop_open),
    .O_TACH_SRC(tach_src));
  mcrb_host_model host (.i_clk(clk), .i_tach_out(tach_out),
    .i_tach_oe_b(tach_oe_b), .i_alert_out(alert_out),
    .i_alert_oe_b(alert_oe_b), .o_sel_b(sel_b), .o_sck(sck),
    .o_tach_pin(tach_pin));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // address 9 keeps only its two stall timing bits
  function automatic logic [15:0] kept(input int a, input logic [15:0] v);
    return (a == 9) ? (v & ADDR9_MASK) : v;
  endfunction : kept
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic bad(input string what);
    n_mismatch++;
    $display("ERROR at %0t: %s", $time, what);
  endtask : bad
  task automatic chk1(input logic g, input logic e, input string what);
    checks_done++;
    if (g !== e) bad(what);
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
      input string what);
    checks_done++;
    if (g !== e) bad(what);
  endtask : chk8
  task automatic chk16(input logic [15:0] g, input logic [15:0] e,
      input string what);
    checks_done++;
    if (g !== e) bad(what);
  endtask : chk16
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (status[SR_BUSY_BIT] !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk1(status[SR_BUSY_BIT], 1'b0, "busy never cleared");
  endtask : wait_idle
  task automatic reset_and_check;
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk8(status, 8'h00, "status reset");
    chk1(tach_oe_b, 1'b1, "tach drive at reset");
    chk1(alert_oe_b, 1'b1, "alert drive at reset");
    for (int a = 0; a < NUM_WORDS; a++) begin
      shadow[a] = WORD_RESET;
      chk16(words[16*a+:16], 16'h0000, "word reset");
    end
    $display("test reset done");
  endtask : reset_and_check
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad("timeout");
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    cal_fail = 1'b0;
    rnd = 32'hd1df;
    reset_and_check();
    host.reg_wr(8'h01, 16'hffff);
    chk16(words[31:16], 16'h0000, "closed gate took write");
    chk1(serial_mode, 1'b0, "serial mode after gated frame");
    host.sr_wr(8'hf2);
    host.sr_rd(b);
    chk8(b, 8'h02, "status write mask");
    chk1(serial_mode, 1'b1, "serial mode with gate open");
    $display("test gate done");
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        host.sr_wr(8'h06);
        host.wire2 = 1'b1;
      end
      for (int a = 0; a < NUM_WORDS; a++) begin
        rnd = lfsr(rnd);
        got = (a == 3 * p) ? 16'hffff : rnd[15:0];
        shadow[a] = kept(a, got);
        host.reg_wr(a[7:0], got);
      end
      for (int a = 0; a < NUM_WORDS; a++) begin
        host.reg_rd(a[7:0], got);
        chk16(got, shadow[a], "read back");
        chk16(words[16*a+:16], shadow[a], "word out");
      end
      chk1(loop_open, shadow[LOOP_MODE_ADDR][0], "loop mode");
      chk1(tach_src, shadow[TACH_SRC_ADDR][15], "tach source");
      $display("test words pass %0d done", p);
    end
    host.reg_wr(8'h0a, 16'h5a5a);
    host.reg_rd(8'h0a, got);
    chk16(got, 16'h0000, "unmapped read");
    cal_fail = 1'b1;
    host.sr_rd(b);
    chk8(b, 8'h16, "hall fail flag");
    rnd = lfsr(rnd);
    cal_fail = rnd[0];
    host.sr_rd(b);
    chk8(b, {3'b000, rnd[0], 4'h6}, "random hall flag");
    cal_fail = 1'b0;
    host.sr_wr(8'h17);
    host.sr_rd(b);
    chk8(b, 8'h06, "read-only status bits");
    host.cmd(CODE_NONVOLATILE_SAVE_OP);
    chk1(status[SR_BUSY_BIT], 1'b0, "save with write gate low");
    host.sr_wr(8'h0e);
    shadow[1] = 16'h1234;
    host.reg_wr(8'h01, 16'h1234);
    host.cmd(CODE_NONVOLATILE_SAVE_OP);
    chk1(status[SR_BUSY_BIT], 1'b1, "busy in save");
    host.cmd(CODE_NONVOLATILE_ABORT_OP);
    wait_idle(20);
    host.cmd(CODE_NONVOLATILE_SAVE_OP);
    wait_idle(600);
    host.reg_wr(8'h01, 16'h0000);
    host.cmd(CODE_NONVOLATILE_LOAD_OP);
    chk1(status[SR_BUSY_BIT], 1'b0, "load with write gate high");
    host.sr_wr(8'h06);
    host.cmd(CODE_NONVOLATILE_LOAD_OP);
    chk1(status[SR_BUSY_BIT], 1'b1, "busy in load");
    wait_idle(100);
    for (int a = 0; a < NUM_WORDS; a++) begin
      chk16(words[16*a+:16], shadow[a], "loaded word");
    end
    $display("test nonvolatile done");
    host.sr_wr(8'h04);
    chk1(serial_mode, 1'b0, "leave serial mode");
    host.reg_wr(8'h02, 16'hbeef);
    chk16(words[47:32], shadow[2], "closed gate two-wire");
    host.sr_rd(b);
    chk8(b, 8'h04, "status read two-wire");
    $display("test close done");
    reset_and_check();
    chk1(host.n_viol == 0, 1'b1, "frame while tach driven");
    tally_and_finish();
  end
endmodule : test_motor_config_register_bank
